/* File: hdl/ccr_readout.sv */
// Charge counter read-out register bank with AXI4-Lite slave
// Operation
// - The low eight bits of the output_a counter read back through a read-only byte register.
// - The high eight bits of the output_b active-mode counter read back through a read-only register reset to zero.
// - Each counter step stands for a number of converter pulses chosen by prescale_select.
// - Each counter is split over a high and a low byte register and keeps counting when not read.
// - While a counter's registers are addressed its updates are suspended and such counts are lost.
// - Reading a high byte copies that counter's current low byte into its shadow at the same moment.
// - Reading a low byte returns the shadow from the last high-byte read, so high is read before low.
// - The high eight bits of the output_a counter read back through a separate read-only register.
// - The low eight bits of the output_b active-mode counter read back through a read-only register reset to zero.
`timescale 1ns/1ps
`default_nettype none

module ccr_readout #(
	parameter int unsigned COUNT_W = ccr_pkg::COUNT_W
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [ccr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                 s_axi_awprot,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [ccr_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic      [1:0]                 s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ccr_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                 s_axi_arprot,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic      [ccr_pkg::DATA_W-1:0] s_axi_rdata,
	output logic      [1:0]                 s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       output_a_pfm_pulse,
	input  wire logic                       output_b_pfm_pulse,
	input  wire logic                       active_energy_mode
);

	logic                               mode_meta;
	logic                               mode_sync;
	logic                               aw_got;
	logic                               w_got;
	logic [ccr_pkg::ADDR_W-1:0]         aw_addr;
	logic [ccr_pkg::DATA_W-1:0]         w_data;
	logic [3:0]                         w_strb;
	logic [ccr_pkg::PRESCALE_SEL_W-1:0] prescale_select;
	logic [1:0]                         missed_status;
	logic [7:0]                         rd_idx;
	logic                               rd_a_sel;
	logic                               rd_b_sel;
	logic [7:0]                         ar_idx;
	logic [7:0]                         aw_idx;
	logic                               ar_fire;
	logic                               w_commit;
	logic                               ar_is_a;
	logic                               ar_is_b;
	logic [1:0]                         hold;
	logic [1:0]                         snap;
	logic [1:0]                         missed;
	logic [1:0]                         pfm_pulse;
	logic [1:0]                         count_en;
	logic [COUNT_W-1:0]                 count [2];
	logic [ccr_pkg::BYTE_W-1:0]         shadow [2];
	logic [ccr_pkg::DATA_W-1:0]         next_rdata;
	logic [1:0]                         next_rresp;
	logic [1:0]                         next_bresp;

	// Synchroniser for the energy mode pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_meta <= 1'b0;
			mode_sync <= 1'b0;
		end else begin
			mode_meta <= active_energy_mode;
			mode_sync <= mode_meta;
		end
	end

	assign ar_idx  = {2'b00, s_axi_araddr[ccr_pkg::ADDR_W-1:2]};
	assign aw_idx  = {2'b00, aw_addr[ccr_pkg::ADDR_W-1:2]};
	assign ar_fire = s_axi_arvalid && s_axi_arready;
	assign ar_is_a = (ar_idx == ccr_pkg::IDX_A_HIGH) || (ar_idx == ccr_pkg::IDX_A_LOW);
	assign ar_is_b = (ar_idx == ccr_pkg::IDX_B_HIGH) || (ar_idx == ccr_pkg::IDX_B_LOW);

	// Hold from the moment a read addresses a counter until its data is taken
	assign hold[0] = (s_axi_arvalid && ar_is_a) || (s_axi_rvalid && rd_a_sel);
	assign hold[1] = (s_axi_arvalid && ar_is_b) || (s_axi_rvalid && rd_b_sel);
	assign snap[0] = ar_fire && (ar_idx == ccr_pkg::IDX_A_HIGH);
	assign snap[1] = ar_fire && (ar_idx == ccr_pkg::IDX_B_HIGH);

	assign pfm_pulse[0] = output_a_pfm_pulse;
	assign pfm_pulse[1] = output_b_pfm_pulse;
	assign count_en[0]  = 1'b1;
	assign count_en[1]  = mode_sync;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_counter
			ccr_counter #(
				.COUNT_W (COUNT_W)
			) u_counter (
				.aclk            (aclk),
				.aresetn         (aresetn),
				.pfm_pulse       (pfm_pulse[i]),
				.count_en        (count_en[i]),
				.prescale_select (prescale_select),
				.hold            (hold[i]),
				.snap            (snap[i]),
				.count           (count[i]),
				.shadow          (shadow[i]),
				.missed          (missed[i])
			);
		end
	endgenerate

	// Read data mux
	always_comb begin
		next_rdata = '0;
		next_rresp = ccr_pkg::RESP_OKAY;
		unique case (ar_idx)
			ccr_pkg::IDX_A_HIGH: begin
				next_rdata[7:0] = count[0][COUNT_W-1 -: 8];
			end
			ccr_pkg::IDX_A_LOW: begin
				next_rdata[7:0] = shadow[0];
			end
			ccr_pkg::IDX_B_HIGH: begin
				next_rdata[7:0] = count[1][COUNT_W-1 -: 8];
			end
			ccr_pkg::IDX_B_LOW: begin
				next_rdata[7:0] = shadow[1];
			end
			ccr_pkg::IDX_CTRL: begin
				next_rdata[ccr_pkg::CTRL_PRESCALE_LSB +: ccr_pkg::PRESCALE_SEL_W] = prescale_select;
			end
			ccr_pkg::IDX_STATUS: begin
				next_rdata[1:0] = missed_status;
			end
			default: begin
				next_rresp = ccr_pkg::RESP_SLVERR;
			end
		endcase
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= ccr_pkg::RESP_OKAY;
			rd_idx        <= '0;
		end else if (ar_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
			rd_idx        <= ar_idx;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	assign rd_a_sel = (rd_idx == ccr_pkg::IDX_A_HIGH) || (rd_idx == ccr_pkg::IDX_A_LOW);
	assign rd_b_sel = (rd_idx == ccr_pkg::IDX_B_HIGH) || (rd_idx == ccr_pkg::IDX_B_LOW);

	// Write address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			aw_got        <= 1'b0;
			aw_addr       <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_got        <= 1'b1;
			aw_addr       <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
			aw_got        <= 1'b0;
		end else if (!aw_got) begin
			s_axi_awready <= 1'b1;
		end
	end

	// Write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
			w_got        <= 1'b0;
			w_data       <= '0;
			w_strb       <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_got        <= 1'b1;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
			w_got        <= 1'b0;
		end else if (!w_got) begin
			s_axi_wready <= 1'b1;
		end
	end

	assign w_commit = aw_got && w_got && !s_axi_bvalid;

	// Write response; counter registers accept and discard
	always_comb begin
		unique case (aw_idx)
			ccr_pkg::IDX_A_HIGH,
			ccr_pkg::IDX_A_LOW,
			ccr_pkg::IDX_B_HIGH,
			ccr_pkg::IDX_B_LOW,
			ccr_pkg::IDX_CTRL,
			ccr_pkg::IDX_STATUS: begin
				next_bresp = ccr_pkg::RESP_OKAY;
			end
			default: begin
				next_bresp = ccr_pkg::RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ccr_pkg::RESP_OKAY;
		end else if (w_commit) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= next_bresp;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Prescale select
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescale_select <= ccr_pkg::RST_PRESCALE;
		end else if (w_commit && aw_idx == ccr_pkg::IDX_CTRL && w_strb[0]) begin
			prescale_select <= w_data[ccr_pkg::CTRL_PRESCALE_LSB +: ccr_pkg::PRESCALE_SEL_W];
		end
	end

	// Missed-count flags, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			missed_status <= 2'h0;
		end else if (w_commit && aw_idx == ccr_pkg::IDX_STATUS && w_strb[0]) begin
			missed_status <= (missed_status & ~w_data[1:0]) | missed;
		end else begin
			missed_status <= missed_status | missed;
		end
	end

	logic unused_ok;
	assign unused_ok = ^{s_axi_awprot, s_axi_arprot, aw_addr[1:0], w_data[31:8], w_strb[3:1]};

endmodule : ccr_readout

`default_nettype wire

/* File: common/ccr_pkg.sv */
// Package with register map, field layout and reset values of the charge counter read-out
package ccr_pkg;

	localparam int unsigned ADDR_W          = 8;
	localparam int unsigned DATA_W          = 32;
	localparam int unsigned COUNT_W         = 16;
	localparam int unsigned BYTE_W          = 8;
	localparam int unsigned PRESCALE_SEL_W  = 2;
	localparam int unsigned PRESCALE_W      = 6;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_A_HIGH       = 8'h13;
	localparam logic [7:0] IDX_A_LOW        = 8'h14;
	localparam logic [7:0] IDX_B_HIGH       = 8'h15;
	localparam logic [7:0] IDX_B_LOW        = 8'h16;
	localparam logic [7:0] IDX_CTRL         = 8'h20;
	localparam logic [7:0] IDX_STATUS       = 8'h21;

	// Reset values
	localparam logic [7:0]  RST_CHARGE      = 8'h00;
	localparam logic [15:0] RST_COUNT       = 16'h0000;
	localparam logic [1:0]  RST_PRESCALE    = 2'h0;

	// Control register fields
	localparam int unsigned CTRL_PRESCALE_LSB = 0;

	// Status register fields, sticky, write one to clear
	localparam int unsigned STAT_A_MISSED   = 0;
	localparam int unsigned STAT_B_MISSED   = 1;

	// Prescaler terminal counts: 1, 4, 16 or 64 pulses per count
	localparam logic [5:0] PRESCALE_TC [4]  = '{6'h00, 6'h03, 6'h0F, 6'h3F};

	// Bus responses
	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_SLVERR      = 2'h2;

endpackage : ccr_pkg

/* File: hdl/ccr_counter.sv */
// One charge counter with pulse synchroniser, prescaler, update hold and low-byte shadow
`timescale 1ns/1ps
`default_nettype none

module ccr_counter #(
	parameter int unsigned COUNT_W = ccr_pkg::COUNT_W
) (
	input  wire logic                               aclk,
	input  wire logic                               aresetn,
	input  wire logic                               pfm_pulse,
	input  wire logic                               count_en,
	input  wire logic [ccr_pkg::PRESCALE_SEL_W-1:0] prescale_select,
	input  wire logic                               hold,
	input  wire logic                               snap,
	output logic      [COUNT_W-1:0]                 count,
	output logic      [ccr_pkg::BYTE_W-1:0]         shadow,
	output logic                                    missed
);

	logic                               pulse_meta;
	logic                               pulse_sync;
	logic                               pulse_prev;
	logic [ccr_pkg::PRESCALE_W-1:0]     prescale_cnt;
	logic                               pulse_edge;
	logic                               tick;

	// Two-stage synchroniser for the converter pulse pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pulse_meta <= 1'b0;
			pulse_sync <= 1'b0;
			pulse_prev <= 1'b0;
		end else begin
			pulse_meta <= pfm_pulse;
			pulse_sync <= pulse_meta;
			pulse_prev <= pulse_sync;
		end
	end

	assign pulse_edge = pulse_sync && !pulse_prev && count_en;
	assign tick       = pulse_edge && (prescale_cnt == ccr_pkg::PRESCALE_TC[prescale_select]);

	// Prescaler: one count per selected number of pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescale_cnt <= '0;
		end else if (tick) begin
			prescale_cnt <= '0;
		end else if (pulse_edge) begin
			prescale_cnt <= prescale_cnt + 1'b1;
		end
	end

	// Counter, frozen while its registers are addressed; resumes from held value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= ccr_pkg::RST_COUNT;
		end else if (tick && !hold) begin
			count <= count + 1'b1;
		end
	end

	// A count that falls in a hold is dropped and reported
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			missed <= 1'b0;
		end else begin
			missed <= tick && hold;
		end
	end

	// Low byte copied at the moment the high byte is read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shadow <= ccr_pkg::RST_CHARGE;
		end else if (snap) begin
			shadow <= count[ccr_pkg::BYTE_W-1:0];
		end
	end

endmodule : ccr_counter

`default_nettype wire

/* File: tb/ccr_readout_assertions.sv */
// Checker with bus and read-back assertions of the charge counter read-out
`timescale 1ns/1ps
`default_nettype none
module ccr_readout_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	logic [7:0] ar_q;
	logic       cnt_reg;
	logic       unm;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_q <= 8'h00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			ar_q <= s_axi_araddr;
		end
	end
	assign cnt_reg = (ar_q >= 8'h4C) && (ar_q <= 8'h58) && (ar_q[1:0] == 2'h0);
	assign unm     = !cnt_reg && (ar_q != 8'h80) && (ar_q != 8'h84);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_rvalid_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer changed");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer changed");
	a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while pending");
	a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
		##2 s_axi_bvalid) else $error("write answer late");
	a_byte_reads: assert property (s_axi_rvalid && cnt_reg |->
		s_axi_rresp == ccr_pkg::RESP_OKAY && s_axi_rdata[31:8] == 24'h0) else $error("bad byte read");
	a_unmapped_err: assert property (s_axi_rvalid && unm |-> s_axi_rresp == ccr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
	c_unmapped: cover property (s_axi_rvalid && unm);
	c_slow_read: cover property ((s_axi_rvalid && !s_axi_rready) [*3]);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // ccr_readout_assertions
bind ccr_readout ccr_readout_assertions u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

/* File: tb/ccr_readout_tb.sv */
// Self-checking bench of the charge counter read-out
`timescale 1ns/1ps
`default_nettype none
module ccr_readout_tb;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        pulse_a, pulse_b, aem;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          bad_count, checks_done, cnt_a;

	ccr_readout DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.output_a_pfm_pulse(pulse_a), .output_b_pfm_pulse(pulse_b), .active_energy_mode(aem));

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task tmo;
		bad_count++;
		$display("BAD handshake expected done seen timeout");
		test_done;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rd(input logic [7:0] i, input int dly);
		int n;
		s_axi_araddr <= {i[5:0], 2'b00};
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) break;
		end
		if (n == 50) tmo;
		s_axi_arvalid <= 1'b0;
		repeat (dly) @(posedge aclk);
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_rvalid === 1'b1) break;
		end
		if (n == 50) tmo;
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] i, input logic [31:0] v);
		int   n;
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= {i[5:0], 2'b00};
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 50 && !(aw && w); n++) begin
			@(posedge aclk);
			if (!aw && s_axi_awready === 1'b1) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (!(aw && w)) tmo;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_bvalid === 1'b1) break;
		end
		if (n == 50) tmo;
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic pulse(input logic b, input int n);
		for (int k = 0; k < n; k++) begin
			pulse_a <= !b;
			pulse_b <= b;
			repeat (2) @(posedge aclk);
			pulse_a <= 1'b0;
			pulse_b <= 1'b0;
			repeat (2) @(posedge aclk);
		end
		repeat (4) @(posedge aclk);
	endtask

	task chk_pair(input logic [7:0] hi, input logic [15:0] e);
		rd(hi, 0);
		chk("high byte", {24'h0, e[15:8]}, d);
		rd(hi + 8'h01, 0);
		chk("low byte", {24'h0, e[7:0]}, d);
		chk("read resp", 32'(ccr_pkg::RESP_OKAY), {30'h0, r});
	endtask

	task t_reset;
		logic [7:0] regs [4];
		regs = '{ccr_pkg::IDX_A_LOW, ccr_pkg::IDX_A_HIGH, ccr_pkg::IDX_B_LOW, ccr_pkg::IDX_B_HIGH};
		for (int k = 0; k < 4; k++) begin
			rd(regs[k], 0);
			chk("reset value", {24'h0, ccr_pkg::RST_CHARGE}, d);
		end
	endtask

	task t_count_a;
		pulse(1'b0, 260);
		chk_pair(ccr_pkg::IDX_A_HIGH, 16'h0104);
		rd(ccr_pkg::IDX_A_HIGH, 0);
		pulse(1'b0, 3);
		rd(ccr_pkg::IDX_A_LOW, 0);
		chk("shadow low", 32'h04, d);
		cnt_a = 263;
		chk_pair(ccr_pkg::IDX_A_HIGH, 16'(cnt_a));
	endtask

	task t_prescale;
		for (int s = 1; s < 4; s++) begin
			wr(ccr_pkg::IDX_CTRL, 32'(s));
			rd(ccr_pkg::IDX_CTRL, 0);
			chk("prescale_select", 32'(s), d);
			pulse(1'b0, int'(ccr_pkg::PRESCALE_TC[s]));
			chk_pair(ccr_pkg::IDX_A_HIGH, 16'(cnt_a));
			pulse(1'b0, 1);
			cnt_a++;
			chk_pair(ccr_pkg::IDX_A_HIGH, 16'(cnt_a));
		end
		wr(ccr_pkg::IDX_CTRL, 32'h0);
	endtask

	task t_gate_b;
		pulse(1'b1, 5);
		chk_pair(ccr_pkg::IDX_B_HIGH, 16'h0000);
		aem <= 1'b1;
		repeat (4) @(posedge aclk);
		pulse(1'b1, 300);
		chk_pair(ccr_pkg::IDX_B_HIGH, 16'd300);
	endtask

	task t_write_ignored;
		for (logic [7:0] i = ccr_pkg::IDX_A_HIGH; i <= ccr_pkg::IDX_B_LOW; i++) begin
			wr(i, 32'hFF);
			chk("write resp", 32'(ccr_pkg::RESP_OKAY), {30'h0, r});
		end
		chk_pair(ccr_pkg::IDX_A_HIGH, 16'(cnt_a));
		chk_pair(ccr_pkg::IDX_B_HIGH, 16'd300);
	endtask

	task t_unmapped;
		rd(8'h3C, 0);
		chk("unmapped data", 32'h0, d);
		chk("unmapped resp", 32'(ccr_pkg::RESP_SLVERR), {30'h0, r});
		wr(8'h3C, 32'h1);
		chk("unmapped wresp", 32'(ccr_pkg::RESP_SLVERR), {30'h0, r});
	endtask

	task t_hold;
		fork
			rd(ccr_pkg::IDX_A_HIGH, 20);
			pulse(1'b0, 3);
		join
		chk("held high", 32'(cnt_a >> 8), d);
		fork
			rd(ccr_pkg::IDX_B_HIGH, 20);
			pulse(1'b1, 3);
		join
		chk("held high b", 32'h01, d);
		rd(ccr_pkg::IDX_STATUS, 0);
		chk("missed flag", 32'h3, d);
		wr(ccr_pkg::IDX_STATUS, 32'h3);
		rd(ccr_pkg::IDX_STATUS, 0);
		chk("missed clear", 32'h0, d);
		pulse(1'b0, 2);
		cnt_a += 2;
		chk_pair(ccr_pkg::IDX_A_HIGH, 16'(cnt_a));
		pulse(1'b1, 2);
		chk_pair(ccr_pkg::IDX_B_HIGH, 16'd302);
	endtask

	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{pulse_a, pulse_b, aem} = 3'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		bad_count = 0;
		checks_done = 0;
		cnt_a = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset;
		t_count_a;
		t_prescale;
		t_gate_b;
		t_write_ignored;
		t_unmapped;
		t_hold;
		test_done;
	end
endmodule // ccr_readout_tb
`default_nettype wire
